/* File: src/sbb_pkg.sv */
/*
  shared constants of the blend and buffer select register bank.
  assumes a 32-bit memory-mapped register port with word-aligned byte offsets.
*/
package sbb_pkg;
  // register offsets
  localparam logic [15:0] OFS_BLEND = 16'h81a0;
  localparam logic [15:0] OFS_PRI_BASE0 = 16'h81c0;
  localparam logic [15:0] OFS_PRI_BASE1 = 16'h81c4;
  localparam logic [15:0] OFS_PRI_STRIDE = 16'h81c8;
  localparam logic [15:0] OFS_DBUF = 16'h81cc;
  localparam logic [15:0] OFS_SEC_BASE0 = 16'h81d0;
  localparam logic [15:0] OFS_SEC_BASE1 = 16'h81d4;
  localparam logic [15:0] OFS_SEC_STRIDE = 16'h81d8;
  // field positions
  localparam int KS_LSB = 2;
  localparam int KP_LSB = 10;
  localparam int MODE_LSB = 24;
  localparam int COEF_W = 3;
  localparam int MODE_W = 3;
  localparam int ADDR_W = 22;
  localparam int STRIDE_W = 12;
  localparam int PBS_BIT = 0;
  localparam int SBS_LSB = 1;
  localparam int LIS_BIT = 4;
  localparam int LSL_BIT = 5;
  localparam int LST_BIT = 6;
  // reset values
  localparam logic [31:0] BLEND_RST = 32'h0000_0000;
  localparam logic [6:0] DBUF_RST = 7'h00;
  // full blend weight
  localparam logic [3:0] COEF_FULL = 4'h8;
  // compose modes
  localparam logic [2:0] MODE_SEC_OPAQUE = 3'h0;
  localparam logic [2:0] MODE_PRI_OPAQUE = 3'h1;
  localparam logic [2:0] MODE_DISSOLVE = 3'h2;
  localparam logic [2:0] MODE_FADE = 3'h3;
  localparam logic [2:0] MODE_KEY_PRI = 3'h5;
  localparam logic [2:0] MODE_KEY_SEC = 3'h6;
  // secondary select codes
  localparam logic [1:0] SBS_FIRST = 2'h0;
  localparam logic [1:0] SBS_SECOND = 2'h1;
  localparam logic [1:0] SBS_SAME = 2'h2;
  localparam logic [1:0] SBS_OPPOSITE = 2'h3;
endpackage

/* File: src/sbb_blend_lane.sv */
/*
  one colour channel of the stream compositor.
  assumes key match flags arrive from keying logic outside this bank.
*/
`timescale 1ns/10ps
module sbb_blend_lane #(
  parameter int CH_W = 8
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [2:0] mode_in,
  input wire logic [2:0] primary_blend_coeff_in,
  input wire logic [2:0] secondary_blend_coeff_in,
  input wire logic [CH_W-1:0] primary_pixel_value_in,
  input wire logic [CH_W-1:0] secondary_pixel_value_in,
  input wire logic primary_key_hit_in,
  input wire logic secondary_key_hit_in,
  output logic [CH_W-1:0] pixel_out
);
  logic [CH_W-1:0] pix_r;
  logic [CH_W-1:0] pix_nxt;
  logic [CH_W+4:0] sum;
  logic [3:0] wp;
  logic [3:0] ws;

  // weighted sum per mode
  always_comb begin
    wp = {1'b0, primary_blend_coeff_in};
    ws = {1'b0, secondary_blend_coeff_in};
    sum = '0;
    pix_nxt = '0;
    unique case (mode_in)
      sbb_pkg::MODE_SEC_OPAQUE: pix_nxt = secondary_pixel_value_in;
      sbb_pkg::MODE_PRI_OPAQUE: pix_nxt = primary_pixel_value_in;
      sbb_pkg::MODE_DISSOLVE: begin
        ws = 4'(sbb_pkg::COEF_FULL - wp); // secondary coeff ignored
        sum = (CH_W+5)'(primary_pixel_value_in * wp) + (CH_W+5)'(secondary_pixel_value_in * ws);
        pix_nxt = CH_W'(sum >> 3);
      end
      sbb_pkg::MODE_FADE: begin
        sum = (CH_W+5)'(primary_pixel_value_in * wp) + (CH_W+5)'(secondary_pixel_value_in * ws);
        pix_nxt = CH_W'(sum >> 3); // software keeps sum of weights <= 8
      end
      sbb_pkg::MODE_KEY_PRI: begin
        // secondary shows where primary matches the key
        pix_nxt = primary_key_hit_in ? secondary_pixel_value_in : primary_pixel_value_in;
      end
      sbb_pkg::MODE_KEY_SEC: begin
        // primary shows where secondary matches the key
        pix_nxt = secondary_key_hit_in ? primary_pixel_value_in : secondary_pixel_value_in;
      end
      default: pix_nxt = primary_pixel_value_in; // reserved codes pass primary
    endcase
  end

  // output register
  always_ff @(posedge sys_clk_in) begin
    pix_r <= reset_in ? '0 : pix_nxt;
  end

  assign pixel_out = pix_r;
endmodule

/* File: src/sbb_reg_bank.sv */
/*
  blend control, stream base addresses, strides and double buffer select.
  assumes a single-cycle register port and sync pulses from display and video input.
*/
`timescale 1ns/10ps
module sbb_reg_bank #(
  parameter int CH_W = 8
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  input wire logic vsync_in,
  input wire logic input_frame_end_in,
  input wire logic line_start_in,
  input wire logic frame_start_in,
  input wire logic [CH_W-1:0] primary_pixel_value_in,
  input wire logic [CH_W-1:0] secondary_pixel_value_in,
  input wire logic primary_key_hit_in,
  input wire logic secondary_key_hit_in,
  output logic [CH_W-1:0] pixel_out,
  output logic [21:0] primary_fetch_addr_out,
  output logic [21:0] secondary_fetch_addr_out,
  output logic [21:0] input_write_base_out,
  output logic input_port_buffer_choice_out
);
  initial begin
    if (CH_W < 1 || CH_W > 16) $error("sbb_reg_bank: CH_W out of range");
  end

  // software-visible blend fields and their live copies
  logic [2:0] ks_sh_r, ks_sh_nxt, kp_sh_r, kp_sh_nxt, mode_sh_r, mode_sh_nxt;
  logic [2:0] ks_r, ks_nxt, kp_r, kp_nxt, mode_r, mode_nxt;
  // address and stride storage
  logic [21:0] pri_base0_r, pri_base0_nxt, pri_base1_r, pri_base1_nxt;
  logic [21:0] sec_base0_r, sec_base0_nxt, sec_base1_r, sec_base1_nxt;
  logic [11:0] pri_stride_r, pri_stride_nxt, sec_stride_r, sec_stride_nxt;
  // double buffer control
  logic primary_buffer_choice_r, primary_buffer_choice_nxt;
  logic [1:0] secondary_buffer_choice_r, secondary_buffer_choice_nxt;
  logic input_port_buffer_choice_r, input_port_buffer_choice_nxt;
  logic input_choice_load_timing_r, input_choice_load_timing_nxt;
  logic input_choice_auto_toggle_r, input_choice_auto_toggle_nxt;
  logic lis_pend_r, lis_pend_nxt, lis_pend_val_r, lis_pend_val_nxt;
  // fetch address walkers and read data
  logic [21:0] pri_fetch_r, pri_fetch_nxt, sec_fetch_r, sec_fetch_nxt;
  logic [21:0] in_base_r, in_base_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic sec_pick_second, wr_blend, wr_dbuf;
  logic [21:0] pri_start, sec_start;

  assign wr_blend = reg_wr_in && reg_addr_in == sbb_pkg::OFS_BLEND;
  assign wr_dbuf = reg_wr_in && reg_addr_in == sbb_pkg::OFS_DBUF;

  // blend shadow and vsync transfer
  always_comb begin
    ks_sh_nxt = ks_sh_r;
    kp_sh_nxt = kp_sh_r;
    mode_sh_nxt = mode_sh_r;
    if (wr_blend) begin
      ks_sh_nxt = reg_wdata_in[sbb_pkg::KS_LSB +: sbb_pkg::COEF_W];
      kp_sh_nxt = reg_wdata_in[sbb_pkg::KP_LSB +: sbb_pkg::COEF_W];
      mode_sh_nxt = reg_wdata_in[sbb_pkg::MODE_LSB +: sbb_pkg::MODE_W];
    end
    ks_nxt = ks_r;
    kp_nxt = kp_r;
    mode_nxt = mode_r;
    if (vsync_in) begin
      ks_nxt = ks_sh_nxt; // write in the vsync cycle also lands
      kp_nxt = kp_sh_nxt;
      mode_nxt = mode_sh_nxt;
    end
  end

  // blend registers
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ks_sh_r <= sbb_pkg::BLEND_RST[sbb_pkg::KS_LSB +: sbb_pkg::COEF_W];
      kp_sh_r <= sbb_pkg::BLEND_RST[sbb_pkg::KP_LSB +: sbb_pkg::COEF_W];
      mode_sh_r <= sbb_pkg::BLEND_RST[sbb_pkg::MODE_LSB +: sbb_pkg::MODE_W];
      ks_r <= sbb_pkg::BLEND_RST[sbb_pkg::KS_LSB +: sbb_pkg::COEF_W];
      kp_r <= sbb_pkg::BLEND_RST[sbb_pkg::KP_LSB +: sbb_pkg::COEF_W];
      mode_r <= sbb_pkg::BLEND_RST[sbb_pkg::MODE_LSB +: sbb_pkg::MODE_W];
    end else begin
      ks_sh_r <= ks_sh_nxt;
      kp_sh_r <= kp_sh_nxt;
      mode_sh_r <= mode_sh_nxt;
      ks_r <= ks_nxt;
      kp_r <= kp_nxt;
      mode_r <= mode_nxt;
    end
  end

  // address and stride stores, not reset
  always_comb begin
    pri_base0_nxt = pri_base0_r;
    pri_base1_nxt = pri_base1_r;
    sec_base0_nxt = sec_base0_r;
    sec_base1_nxt = sec_base1_r;
    pri_stride_nxt = pri_stride_r;
    sec_stride_nxt = sec_stride_r;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        sbb_pkg::OFS_PRI_BASE0: pri_base0_nxt = reg_wdata_in[sbb_pkg::ADDR_W-1:0];
        sbb_pkg::OFS_PRI_BASE1: pri_base1_nxt = reg_wdata_in[sbb_pkg::ADDR_W-1:0];
        sbb_pkg::OFS_SEC_BASE0: sec_base0_nxt = reg_wdata_in[sbb_pkg::ADDR_W-1:0];
        sbb_pkg::OFS_SEC_BASE1: sec_base1_nxt = reg_wdata_in[sbb_pkg::ADDR_W-1:0];
        sbb_pkg::OFS_PRI_STRIDE: pri_stride_nxt = reg_wdata_in[sbb_pkg::STRIDE_W-1:0];
        sbb_pkg::OFS_SEC_STRIDE: sec_stride_nxt = reg_wdata_in[sbb_pkg::STRIDE_W-1:0];
        default: ; // other offsets belong elsewhere
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    pri_base0_r <= pri_base0_nxt;
    pri_base1_r <= pri_base1_nxt;
    sec_base0_r <= sec_base0_nxt;
    sec_base1_r <= sec_base1_nxt;
    pri_stride_r <= pri_stride_nxt;
    sec_stride_r <= sec_stride_nxt;
  end

  // double buffer select with frame-end load and toggle
  always_comb begin
    primary_buffer_choice_nxt = primary_buffer_choice_r;
    secondary_buffer_choice_nxt = secondary_buffer_choice_r;
    input_choice_load_timing_nxt = input_choice_load_timing_r;
    input_choice_auto_toggle_nxt = input_choice_auto_toggle_r;
    input_port_buffer_choice_nxt = input_port_buffer_choice_r;
    lis_pend_nxt = lis_pend_r;
    lis_pend_val_nxt = lis_pend_val_r;
    if (input_frame_end_in) begin
      if (lis_pend_r) begin
        input_port_buffer_choice_nxt = lis_pend_val_r; // load first
        lis_pend_nxt = 1'b0;
      end
      if (input_choice_auto_toggle_r) begin
        input_port_buffer_choice_nxt = ~input_port_buffer_choice_nxt; // then toggle
      end
    end
    if (wr_dbuf) begin
      primary_buffer_choice_nxt = reg_wdata_in[sbb_pkg::PBS_BIT];
      secondary_buffer_choice_nxt = reg_wdata_in[sbb_pkg::SBS_LSB +: 2];
      input_choice_load_timing_nxt = reg_wdata_in[sbb_pkg::LSL_BIT];
      input_choice_auto_toggle_nxt = reg_wdata_in[sbb_pkg::LST_BIT];
      if (reg_wdata_in[sbb_pkg::LSL_BIT]) begin
        lis_pend_nxt = 1'b1; // held until frame end
        lis_pend_val_nxt = reg_wdata_in[sbb_pkg::LIS_BIT];
      end else begin
        lis_pend_nxt = 1'b0;
        input_port_buffer_choice_nxt = reg_wdata_in[sbb_pkg::LIS_BIT]; // at once
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      primary_buffer_choice_r <= sbb_pkg::DBUF_RST[sbb_pkg::PBS_BIT];
      secondary_buffer_choice_r <= sbb_pkg::DBUF_RST[sbb_pkg::SBS_LSB +: 2];
      input_port_buffer_choice_r <= sbb_pkg::DBUF_RST[sbb_pkg::LIS_BIT];
      input_choice_load_timing_r <= sbb_pkg::DBUF_RST[sbb_pkg::LSL_BIT];
      input_choice_auto_toggle_r <= sbb_pkg::DBUF_RST[sbb_pkg::LST_BIT];
      lis_pend_r <= 1'b0;
      lis_pend_val_r <= 1'b0;
    end else begin
      primary_buffer_choice_r <= primary_buffer_choice_nxt;
      secondary_buffer_choice_r <= secondary_buffer_choice_nxt;
      input_port_buffer_choice_r <= input_port_buffer_choice_nxt;
      input_choice_load_timing_r <= input_choice_load_timing_nxt;
      input_choice_auto_toggle_r <= input_choice_auto_toggle_nxt;
      lis_pend_r <= lis_pend_nxt;
      lis_pend_val_r <= lis_pend_val_nxt;
    end
  end

  // fetch start selection and per-line walk
  always_comb begin
    unique case (secondary_buffer_choice_r)
      sbb_pkg::SBS_FIRST: sec_pick_second = 1'b0;
      sbb_pkg::SBS_SECOND: sec_pick_second = 1'b1;
      sbb_pkg::SBS_SAME: sec_pick_second = input_port_buffer_choice_r;
      default: sec_pick_second = ~input_port_buffer_choice_r;
    endcase
    pri_start = primary_buffer_choice_r ? pri_base1_r : pri_base0_r;
    sec_start = sec_pick_second ? sec_base1_r : sec_base0_r;
    pri_fetch_nxt = pri_fetch_r;
    sec_fetch_nxt = sec_fetch_r;
    if (frame_start_in) begin
      pri_fetch_nxt = pri_start;
      sec_fetch_nxt = sec_start;
    end else if (line_start_in) begin
      pri_fetch_nxt = pri_fetch_r + {10'h000, pri_stride_r};
      sec_fetch_nxt = sec_fetch_r + {10'h000, sec_stride_r};
    end
    // follows the next select so the index output does not lag the select bit
    in_base_nxt = input_port_buffer_choice_nxt ? 22'h000001 : 22'h000000;
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pri_fetch_r <= '0;
      sec_fetch_r <= '0;
      in_base_r <= '0;
    end else begin
      pri_fetch_r <= pri_fetch_nxt;
      sec_fetch_r <= sec_fetch_nxt;
      in_base_r <= in_base_nxt;
    end
  end

  // read mux, reserved bits zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        sbb_pkg::OFS_BLEND: begin
          rdata_nxt[sbb_pkg::KS_LSB +: sbb_pkg::COEF_W] = ks_sh_r;
          rdata_nxt[sbb_pkg::KP_LSB +: sbb_pkg::COEF_W] = kp_sh_r;
          rdata_nxt[sbb_pkg::MODE_LSB +: sbb_pkg::MODE_W] = mode_sh_r;
        end
        sbb_pkg::OFS_PRI_BASE0: rdata_nxt[sbb_pkg::ADDR_W-1:0] = pri_base0_r;
        sbb_pkg::OFS_PRI_BASE1: rdata_nxt[sbb_pkg::ADDR_W-1:0] = pri_base1_r;
        sbb_pkg::OFS_SEC_BASE0: rdata_nxt[sbb_pkg::ADDR_W-1:0] = sec_base0_r;
        sbb_pkg::OFS_SEC_BASE1: rdata_nxt[sbb_pkg::ADDR_W-1:0] = sec_base1_r;
        sbb_pkg::OFS_PRI_STRIDE: rdata_nxt[sbb_pkg::STRIDE_W-1:0] = pri_stride_r;
        sbb_pkg::OFS_SEC_STRIDE: rdata_nxt[sbb_pkg::STRIDE_W-1:0] = sec_stride_r;
        sbb_pkg::OFS_DBUF: begin
          rdata_nxt[sbb_pkg::PBS_BIT] = primary_buffer_choice_r;
          rdata_nxt[sbb_pkg::SBS_LSB +: 2] = secondary_buffer_choice_r;
          rdata_nxt[sbb_pkg::LIS_BIT] = input_port_buffer_choice_r; // live select
          rdata_nxt[sbb_pkg::LSL_BIT] = input_choice_load_timing_r;
          rdata_nxt[sbb_pkg::LST_BIT] = input_choice_auto_toggle_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    rdata_r <= reset_in ? 32'h0000_0000 : rdata_nxt;
  end

  // compositing datapath on live coefficients
  sbb_blend_lane #(
    .CH_W(CH_W)
  ) u_lane (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .mode_in(mode_r),
    .primary_blend_coeff_in(kp_r),
    .secondary_blend_coeff_in(ks_r),
    .primary_pixel_value_in(primary_pixel_value_in),
    .secondary_pixel_value_in(secondary_pixel_value_in),
    .primary_key_hit_in(primary_key_hit_in),
    .secondary_key_hit_in(secondary_key_hit_in),
    .pixel_out(pixel_out)
  );

  assign reg_rdata_out = rdata_r;
  assign primary_fetch_addr_out = pri_fetch_r;
  assign secondary_fetch_addr_out = sec_fetch_r;
  assign input_write_base_out = in_base_r;
  assign input_port_buffer_choice_out = input_port_buffer_choice_r;
endmodule

/* File: tb/sbb_reg_bank_properties.sv */
/*
  port checker for the blend and buffer select register bank.
  assumes one clock, sync active-high reset, bound to every sbb_reg_bank.
*/
`timescale 1ns/10ps
module sbb_reg_bank_properties #(
  parameter int CH_W = 8
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic vsync_in,
  input wire logic input_frame_end_in,
  input wire logic line_start_in,
  input wire logic frame_start_in,
  input wire logic [CH_W-1:0] secondary_pixel_value_in,
  input wire logic [CH_W-1:0] pixel_out,
  input wire logic [21:0] primary_fetch_addr_out,
  input wire logic [21:0] secondary_fetch_addr_out,
  input wire logic input_port_buffer_choice_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  logic seen_vsync_r, seen_vsync_nxt;
  logic [11:0] pri_stride_r, pri_stride_nxt, sec_stride_r, sec_stride_nxt;
  logic mapped;
  logic dbuf_wr;
  // decode of the watched register accesses
  assign mapped = reg_addr_in inside {sbb_pkg::OFS_BLEND, sbb_pkg::OFS_PRI_BASE0,
    sbb_pkg::OFS_PRI_BASE1, sbb_pkg::OFS_PRI_STRIDE, sbb_pkg::OFS_DBUF,
    sbb_pkg::OFS_SEC_BASE0, sbb_pkg::OFS_SEC_BASE1, sbb_pkg::OFS_SEC_STRIDE};
  assign dbuf_wr = reg_wr_in && reg_addr_in == sbb_pkg::OFS_DBUF;
  // next values of the tracked strides and first-vsync flag
  always_comb begin
    seen_vsync_nxt = seen_vsync_r | vsync_in;
    pri_stride_nxt = pri_stride_r;
    sec_stride_nxt = sec_stride_r;
    if (reg_wr_in && reg_addr_in == sbb_pkg::OFS_PRI_STRIDE) begin
      pri_stride_nxt = reg_wdata_in[11:0];
    end
    if (reg_wr_in && reg_addr_in == sbb_pkg::OFS_SEC_STRIDE) begin
      sec_stride_nxt = reg_wdata_in[11:0];
    end
  end
  // tracker registers, strides kept through reset like the design
  always_ff @(posedge sys_clk_in) begin
    seen_vsync_r <= reset_in ? 1'b0 : seen_vsync_nxt;
    pri_stride_r <= pri_stride_nxt;
    sec_stride_r <= sec_stride_nxt;
  end
  a_rd_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data not zero without a read");
  a_blend_rsvd_zero: assert property (reg_rd_in && reg_addr_in == sbb_pkg::OFS_BLEND
    |=> (reg_rdata_out & 32'hf8ffe3e3) == 32'h0) else $error("blend reserved bits set");
  a_dbuf_rsvd_zero: assert property (reg_rd_in && reg_addr_in == sbb_pkg::OFS_DBUF
    |=> (reg_rdata_out & 32'hffffff88) == 32'h0) else $error("double buffer reserved bits set");
  a_unmapped_read_zero: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_choice_hold: assert property (!input_frame_end_in && !dbuf_wr
    |=> $stable(input_port_buffer_choice_out)) else $error("input choice moved without cause");
  a_choice_direct: assert property (dbuf_wr && !reg_wdata_in[5]
    |=> input_port_buffer_choice_out == $past(reg_wdata_in[4])) else $error("direct load missed");
  a_pixel_pre_vsync: assert property (!seen_vsync_r
    |=> pixel_out == $past(secondary_pixel_value_in)) else $error("blend live before vsync");
  a_pri_stride_step: assert property (line_start_in && !frame_start_in && !reg_wr_in
    |=> primary_fetch_addr_out == $past(primary_fetch_addr_out) + {10'h0, $past(pri_stride_r)})
    else $error("primary line step wrong");
  a_sec_stride_step: assert property (line_start_in && !frame_start_in && !reg_wr_in
    |=> secondary_fetch_addr_out == $past(secondary_fetch_addr_out) + {10'h0, $past(sec_stride_r)})
    else $error("secondary line step wrong");
endmodule
bind sbb_reg_bank sbb_reg_bank_properties #(.CH_W(CH_W)) sbb_reg_bank_properties_i (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .vsync_in(vsync_in), .input_frame_end_in(input_frame_end_in), .line_start_in(line_start_in),
  .frame_start_in(frame_start_in), .secondary_pixel_value_in(secondary_pixel_value_in),
  .pixel_out(pixel_out), .primary_fetch_addr_out(primary_fetch_addr_out),
  .secondary_fetch_addr_out(secondary_fetch_addr_out),
  .input_port_buffer_choice_out(input_port_buffer_choice_out));

/* File: tb/sbb_reg_bank_bench.sv */
/*
  self-checking bench for the blend and buffer select register bank.
  assumes the bound checker and the package constants.
*/
`timescale 1ns/10ps
module sbb_reg_bank_bench;
  localparam int CH_W = 8;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [15:0] reg_addr_in = 16'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic vsync_in = 1'b0, input_frame_end_in = 1'b0, line_start_in = 1'b0, frame_start_in = 1'b0;
  logic [CH_W-1:0] primary_pixel_value_in = '0, secondary_pixel_value_in = '0;
  logic primary_key_hit_in = 1'b0, secondary_key_hit_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [CH_W-1:0] pixel_out;
  logic [21:0] primary_fetch_addr_out, secondary_fetch_addr_out, input_write_base_out;
  logic input_port_buffer_choice_out;
  int n_fail = 0;
  int compares = 0;
  // design under test
  sbb_reg_bank #(.CH_W(CH_W)) sbb_reg_bank_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .vsync_in(vsync_in),
    .input_frame_end_in(input_frame_end_in), .line_start_in(line_start_in),
    .frame_start_in(frame_start_in), .primary_pixel_value_in(primary_pixel_value_in),
    .secondary_pixel_value_in(secondary_pixel_value_in),
    .primary_key_hit_in(primary_key_hit_in), .secondary_key_hit_in(secondary_key_hit_in),
    .pixel_out(pixel_out), .primary_fetch_addr_out(primary_fetch_addr_out),
    .secondary_fetch_addr_out(secondary_fetch_addr_out),
    .input_write_base_out(input_write_base_out),
    .input_port_buffer_choice_out(input_port_buffer_choice_out));
  // 100 MHz clock
  always #5 sys_clk_in = ~sys_clk_in;
  // verdict and end of run
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // register port cycles
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask
  // one-cycle pulse of {vsync, frame end, frame start, line start}
  task automatic ev(input logic [3:0] e);
    @(posedge sys_clk_in);
    {vsync_in, input_frame_end_in, frame_start_in, line_start_in} <= e;
    @(posedge sys_clk_in);
    {vsync_in, input_frame_end_in, frame_start_in, line_start_in} <= 4'h0;
    #1;
  endtask
  // reference compositor
  function automatic logic [CH_W-1:0] mix(int m, int kp, int ks, int p, int s, int hp, int hs);
    int r;
    case (m)
      0: r = s;
      2: r = (p * kp + s * (8 - kp)) / 8;
      3: r = (p * kp + s * ks) / 8;
      5: r = hp ? s : p;
      6: r = hs ? p : s;
      default: r = p;
    endcase
    return CH_W'(r);
  endfunction
  // random pixel pair through the lane
  task automatic px(input int m, input int kp, input int ks);
    int p, s, hp, hs;
    p = $urandom_range(255);
    s = $urandom_range(255);
    hp = $urandom_range(1);
    hs = $urandom_range(1);
    @(posedge sys_clk_in);
    primary_pixel_value_in <= CH_W'(p);
    secondary_pixel_value_in <= CH_W'(s);
    primary_key_hit_in <= hp[0];
    secondary_key_hit_in <= hs[0];
    @(posedge sys_clk_in);
    #1 chk(32'(pixel_out), 32'(mix(m, kp, ks, p, s, hp, hs)));
  endtask
  // input choice and index output against the model
  task automatic lis_chk(input int li);
    chk(32'(input_port_buffer_choice_out), li);
    chk(32'(input_write_base_out), li);
  endtask
  // watchdog
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  // main sequence
  initial begin
    int d, kp, ks, cm, ckp, cks, se;
    int val[6];
    logic [15:0] ofs[6];
    ofs = '{sbb_pkg::OFS_PRI_BASE0, sbb_pkg::OFS_PRI_BASE1, sbb_pkg::OFS_SEC_BASE0,
      sbb_pkg::OFS_SEC_BASE1, sbb_pkg::OFS_PRI_STRIDE, sbb_pkg::OFS_SEC_STRIDE};
    void'($urandom(48));
    repeat (16) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rd(sbb_pkg::OFS_BLEND, 32'h0);
    rd(sbb_pkg::OFS_DBUF, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      d = (i < 4) ? ($urandom() & 32'hfffffff8) : $urandom();
      val[i] = d & ((i < 4) ? 32'h3fffff : 32'hfff);
      wr(ofs[i], d);
      rd(ofs[i], val[i]);
    end
    wr(16'h81dc, 32'hffffffff);
    rd(16'h81dc, 32'h0);
    $display("register access done");
    for (int c = 0; c < 16; c++) begin
      wr(sbb_pkg::OFS_DBUF, {25'h0, 2'b00, c[3], 1'b0, c[2:1], c[0]});
      se = (c[2:1] == 2'd0) ? 0 : (c[2:1] == 2'd1) ? 1 : (c[2:1] == 2'd2) ? c[3] : !c[3];
      lis_chk(c[3]);
      ev(4'b0010);
      chk(32'(primary_fetch_addr_out), val[c[0]]);
      chk(32'(secondary_fetch_addr_out), val[2 + se]);
      ev(4'b0001);
      chk(32'(primary_fetch_addr_out), (val[c[0]] + val[4]) & 32'h3fffff);
      chk(32'(secondary_fetch_addr_out), (val[2 + se] + val[5]) & 32'h3fffff);
    end
    $display("fetch select done");
    wr(sbb_pkg::OFS_DBUF, 32'hffffff87);
    rd(sbb_pkg::OFS_DBUF, 32'h07);
    wr(sbb_pkg::OFS_DBUF, 32'h30);
    lis_chk(0);
    ev(4'b0100);
    lis_chk(1);
    wr(sbb_pkg::OFS_DBUF, 32'h40);
    ev(4'b0100);
    lis_chk(1);
    ev(4'b0100);
    lis_chk(0);
    wr(sbb_pkg::OFS_DBUF, 32'h70);
    ev(4'b0100);
    lis_chk(0);
    wr(sbb_pkg::OFS_DBUF, 32'h10);
    ev(4'b0100);
    lis_chk(1);
    $display("input buffer choice done");
    cm = 0;
    ckp = 0;
    cks = 0;
    px(0, 0, 0);
    for (int m = 0; m < 8; m++) begin
      kp = $urandom_range(7);
      ks = $urandom_range(7);
      if (m == 3 && kp + ks > 8) ks = 8 - kp;
      wr(sbb_pkg::OFS_BLEND, {5'h1f, m[2:0], 11'h7ff, kp[2:0], 5'h1f, ks[2:0], 2'h3});
      rd(sbb_pkg::OFS_BLEND, {5'h0, m[2:0], 11'h0, kp[2:0], 5'h0, ks[2:0], 2'h0});
      px(cm, ckp, cks);
      ev(4'b1000);
      cm = m;
      ckp = kp;
      cks = ks;
      repeat (6) px(cm, ckp, cks);
    end
    $display("blend modes done");
    close_out();
  end
endmodule
